/* File: verilog/sdc_bank_fsm.sv */
`timescale 1ns/1ps
`default_nettype none

`include "sdc_cfg.svh"

// How it works
// - idle with unselect, nop or halt keeps bank; cke dropping means power-down
// - read with unselect or nop runs burst out, then row stays active, or starts row close if the read had a10 set
// - halt during read ends burst early, bank goes row active, or starts row close if the read had a10 set
// - new read during read aborts burst, fresh burst at new column
// - write during read ends the read and starts a write burst
// - close of this bank or all banks during read starts row close
// - write burst finishes, then write recovery before next command
// - after halt, read data drive stops only after the read latency
// - power-down while cke low, other pins ignored, ends on cke high
module sdc_bank_fsm #(
  parameter int NB      = `SDC_NUM_BANKS,
  parameter int BL      = `SDC_BURST_LEN,
  parameter int CL      = `SDC_CAS_LAT,
  parameter int TWR_CYC = `SDC_WRITE_RECOV,
  parameter int TRP_CYC = `SDC_PRECH_CYC
) (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  // command pins
  input  wire logic                   chip_unselected,
  input  wire logic                   ras_n,
  input  wire logic                   cas_n,
  input  wire logic                   we_n,
  input  wire logic                   cke,
  input  wire logic                   bank_sel,
  input  wire logic                   a10,
  input  wire logic [`SDC_COL_W-1:0]  col,
  // bank status
  output var sdc_pkg::sdc_bank_state_t bank_state [NB],
  output logic                        power_down,
  output logic                        illegal,
  output logic                        dq_drive,
  // event stream
  output logic                        evt_room,
  output logic                        evt_valid,
  input  wire logic                   evt_ready,
  output sdc_pkg::sdc_evt_t           evt_data
);

  localparam int CW = `SDC_CNT_W;
  localparam logic [CW-1:0] BL_LAST  = CW'(BL - 1);
  localparam logic [CW-1:0] WR_LAST  = CW'(TWR_CYC - 1);
  localparam logic [CW-1:0] RP_LAST  = CW'(TRP_CYC - 1);

  sdc_pkg::sdc_pins_t pin_meta;
  sdc_pkg::sdc_pins_t pin_s;
  sdc_pkg::sdc_cmd_t  cmd;
  logic               cmd_live;
  logic [NB-1:0]      bank_illegal;
  logic [NB-1:0]      bank_reading;
  logic [CL-1:0]      beat_pipe;
  logic               evt_push;
  sdc_pkg::sdc_evt_t  next_evt;

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------

  // two flops; only the second is decoded
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta <= '{chip_unselected: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
      pin_s    <= '{chip_unselected: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
    end else begin
      pin_meta <= '{chip_unselected, ras_n, cas_n, we_n, cke, bank_sel, a10, col};
      pin_s    <= pin_meta;
    end
  end

  // ----------------------------------------
  // power-down and command decode
  // ----------------------------------------

  // low cke freezes the bank machines and read pipe, state kept as in clock suspend; the event buffer still drains
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      power_down <= 1'b0;
    end else begin
      power_down <= !pin_s.cke;
    end
  end

  // a command only counts with cke high now and on the previous cycle
  assign cmd_live = pin_s.cke && !power_down;

  always_comb begin
    cmd = sdc_pkg::SDC_CMD_NONE;
    if (!pin_s.chip_unselected) begin
      unique case ({pin_s.ras_n, pin_s.cas_n, pin_s.we_n})
        3'b110: cmd = sdc_pkg::SDC_CMD_HALT;
        3'b101: cmd = sdc_pkg::SDC_CMD_READ;
        3'b100: cmd = sdc_pkg::SDC_CMD_STORE;
        3'b011: cmd = sdc_pkg::SDC_CMD_OPEN;
        3'b010: cmd = sdc_pkg::SDC_CMD_CLOSE;
        3'b001: cmd = sdc_pkg::SDC_CMD_REFR;
        3'b000: cmd = sdc_pkg::SDC_CMD_CONFIG;
        default: cmd = sdc_pkg::SDC_CMD_NONE;
      endcase
    end
  end

  // ----------------------------------------
  // per-bank state machines
  // ----------------------------------------
  for (genvar b = 0; b < NB; b++) begin : g_bank
    logic [CW-1:0] cnt;
    logic          close_after;
    logic          mine;
    logic          closes_me;
    logic          other_rw;

    assign mine      = (pin_s.bank == 1'(b));
    assign closes_me = (cmd == sdc_pkg::SDC_CMD_CLOSE) && (pin_s.a10 || mine);
    assign other_rw  = !mine && (cmd == sdc_pkg::SDC_CMD_READ || cmd == sdc_pkg::SDC_CMD_STORE);
    assign bank_reading[b] = (bank_state[b] == sdc_pkg::SDC_ST_READ);

    // state, burst count and auto-close flag
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        bank_state[b]   <= sdc_pkg::SDC_ST_IDLE;
        cnt             <= '0;
        close_after     <= 1'b0;
        bank_illegal[b] <= 1'b0;
      end else if (!cmd_live) begin
        bank_illegal[b] <= 1'b0; // frozen cycles refuse nothing, so no held flag
      end else begin
        bank_illegal[b] <= 1'b0;
        unique case (bank_state[b])
          sdc_pkg::SDC_ST_IDLE: begin
            // unselect, nop, halt and close leave an idle bank as it is
            if (mine && cmd == sdc_pkg::SDC_CMD_OPEN) begin
              bank_state[b] <= sdc_pkg::SDC_ST_ACTIVE;
            end else if (mine && (cmd == sdc_pkg::SDC_CMD_READ || cmd == sdc_pkg::SDC_CMD_STORE)) begin
              bank_illegal[b] <= 1'b1;
            end
          end
          sdc_pkg::SDC_ST_ACTIVE: begin
            close_after <= pin_s.a10;
            cnt         <= BL_LAST;
            if (closes_me) begin
              bank_state[b] <= sdc_pkg::SDC_ST_PRECH;
              cnt           <= RP_LAST;
            end else if (mine && cmd == sdc_pkg::SDC_CMD_READ) begin
              bank_state[b] <= sdc_pkg::SDC_ST_READ;
            end else if (mine && cmd == sdc_pkg::SDC_CMD_STORE) begin
              bank_state[b] <= sdc_pkg::SDC_ST_WRITE;
            end else if ((mine && cmd == sdc_pkg::SDC_CMD_OPEN) || cmd == sdc_pkg::SDC_CMD_REFR
                         || cmd == sdc_pkg::SDC_CMD_CONFIG) begin
              bank_illegal[b] <= 1'b1;
            end
          end
          sdc_pkg::SDC_ST_READ: begin
            bank_illegal[b] <= (mine && cmd == sdc_pkg::SDC_CMD_OPEN) || cmd == sdc_pkg::SDC_CMD_REFR
                               || cmd == sdc_pkg::SDC_CMD_CONFIG; // refused, burst keeps counting
            if (closes_me) begin
              bank_state[b] <= sdc_pkg::SDC_ST_PRECH;
              cnt           <= RP_LAST;
            end else if (mine && cmd == sdc_pkg::SDC_CMD_READ) begin
              cnt         <= BL_LAST;
              close_after <= pin_s.a10;
            end else if (mine && cmd == sdc_pkg::SDC_CMD_STORE) begin
              bank_state[b] <= sdc_pkg::SDC_ST_WRITE;
              cnt           <= BL_LAST;
              close_after   <= pin_s.a10;
            end else if (cmd == sdc_pkg::SDC_CMD_HALT || other_rw) begin
              // halt stops the beats now; the drive lags by the latency
              bank_state[b] <= close_after ? sdc_pkg::SDC_ST_PRECH : sdc_pkg::SDC_ST_ACTIVE;
              cnt           <= RP_LAST;
            end else if (cnt == '0) begin
              bank_state[b] <= close_after ? sdc_pkg::SDC_ST_PRECH : sdc_pkg::SDC_ST_ACTIVE;
              cnt           <= RP_LAST;
            end else begin
              cnt <= cnt - 1'b1;
            end
          end
          sdc_pkg::SDC_ST_WRITE: begin
            if (closes_me) begin
              bank_state[b] <= sdc_pkg::SDC_ST_PRECH;
              cnt           <= RP_LAST;
            end else if (mine && cmd == sdc_pkg::SDC_CMD_STORE) begin
              cnt         <= BL_LAST;
              close_after <= pin_s.a10;
            end else if (mine && cmd == sdc_pkg::SDC_CMD_READ) begin
              bank_state[b] <= sdc_pkg::SDC_ST_READ;
              cnt           <= BL_LAST;
              close_after   <= pin_s.a10;
            end else if (cnt == '0 || other_rw || cmd == sdc_pkg::SDC_CMD_HALT) begin
              bank_state[b] <= sdc_pkg::SDC_ST_RECOV;
              cnt           <= WR_LAST;
            end else begin
              cnt <= cnt - 1'b1;
            end
          end
          sdc_pkg::SDC_ST_RECOV: begin
            // commands other than halt to this bank are refused until recovery is over
            if (mine && cmd != sdc_pkg::SDC_CMD_NONE && cmd != sdc_pkg::SDC_CMD_HALT) begin
              bank_illegal[b] <= 1'b1;
            end
            if (cnt == '0) begin
              bank_state[b] <= close_after ? sdc_pkg::SDC_ST_PRECH : sdc_pkg::SDC_ST_ACTIVE;
              cnt           <= RP_LAST;
            end else begin
              cnt <= cnt - 1'b1;
            end
          end
          sdc_pkg::SDC_ST_PRECH: begin
            if (mine && (cmd == sdc_pkg::SDC_CMD_READ || cmd == sdc_pkg::SDC_CMD_STORE
                         || cmd == sdc_pkg::SDC_CMD_OPEN)) begin
              bank_illegal[b] <= 1'b1;
            end
            if (cnt == '0) begin
              bank_state[b] <= sdc_pkg::SDC_ST_IDLE;
            end else begin
              cnt <= cnt - 1'b1;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // read data drive and illegal flag
  // ----------------------------------------

  // beats appear on the pins a full read latency after they occur
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      beat_pipe <= '0;
    end else if (cmd_live) begin
      beat_pipe <= {beat_pipe[CL-2:0], |bank_reading};
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dq_drive <= 1'b0;
    end else begin
      dq_drive <= beat_pipe[CL-2] && cmd_live;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      illegal <= 1'b0;
    end else begin
      illegal <= |bank_illegal;
    end
  end

  // ----------------------------------------
  // event stream into the buffer
  // ----------------------------------------

  // one event per decoded read, write or close, refused ones included; a full buffer drops it,
  // which evt_room shows in the same cycle
  always_comb begin
    next_evt             = '0;
    next_evt.bank        = pin_s.bank;
    next_evt.close_after = pin_s.a10;
    next_evt.col         = pin_s.col;
    evt_push             = 1'b0;
    if (cmd_live) begin
      if (cmd == sdc_pkg::SDC_CMD_READ) begin
        next_evt.kind = sdc_pkg::SDC_EVT_READ;
        evt_push      = 1'b1;
      end else if (cmd == sdc_pkg::SDC_CMD_STORE) begin
        next_evt.kind = sdc_pkg::SDC_EVT_WRITE;
        evt_push      = 1'b1;
      end else if (cmd == sdc_pkg::SDC_CMD_CLOSE) begin
        next_evt.kind = sdc_pkg::SDC_EVT_CLOSE;
        evt_push      = 1'b1;
      end
    end
  end

  sdc_buf2 #(
    .W ($bits(sdc_pkg::sdc_evt_t))
  ) u_buf (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .in_valid  (evt_push),
    .in_ready  (evt_room),
    .in_data   (next_evt),
    .out_valid (evt_valid),
    .out_ready (evt_ready),
    .out_data  (evt_data)
  );

endmodule

`default_nettype wire

/* File: verilog/sdc_cfg.svh */
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH

// ----------------------------------------
// widths and defaults
// ----------------------------------------
`define SDC_NUM_BANKS      2
`define SDC_COL_W          8
`define SDC_BURST_LEN      4
`define SDC_CAS_LAT        2
`define SDC_WRITE_RECOV    2
`define SDC_PRECH_CYC      3
`define SDC_CNT_W          4

`endif

/* File: verilog/sdc_pkg.sv */
`include "sdc_cfg.svh"

package sdc_pkg;

  // ----------------------------------------
  // decoded commands
  // ----------------------------------------
  typedef enum logic [3:0] {
    SDC_CMD_NONE   = 4'h0,
    SDC_CMD_HALT   = 4'h1,
    SDC_CMD_READ   = 4'h2,
    SDC_CMD_STORE  = 4'h3,
    SDC_CMD_OPEN   = 4'h4,
    SDC_CMD_CLOSE  = 4'h5,
    SDC_CMD_REFR   = 4'h6,
    SDC_CMD_CONFIG = 4'h7
  } sdc_cmd_t;

  // ----------------------------------------
  // per-bank state, one-hot
  // ----------------------------------------
  typedef enum logic [5:0] {
    SDC_ST_IDLE   = 6'h01,
    SDC_ST_ACTIVE = 6'h02,
    SDC_ST_READ   = 6'h04,
    SDC_ST_WRITE  = 6'h08,
    SDC_ST_RECOV  = 6'h10,
    SDC_ST_PRECH  = 6'h20
  } sdc_bank_state_t;

  typedef enum logic [1:0] {
    SDC_EVT_READ  = 2'h0,
    SDC_EVT_WRITE = 2'h1,
    SDC_EVT_CLOSE = 2'h2
  } sdc_evt_kind_t;

  // command pins as sampled
  typedef struct packed {
    logic                   chip_unselected;
    logic                   ras_n;
    logic                   cas_n;
    logic                   we_n;
    logic                   cke;
    logic                   bank;
    logic                   a10;
    logic [`SDC_COL_W-1:0]  col;
  } sdc_pins_t;

  // event handed to the data path
  typedef struct packed {
    sdc_evt_kind_t          kind;
    logic                   bank;
    logic                   close_after;
    logic [`SDC_COL_W-1:0]  col;
  } sdc_evt_t;

endpackage

/* File: verilog/sdc_buf2.sv */
`timescale 1ns/1ps
`default_nettype none

// two-entry buffer; full and empty are exact
module sdc_buf2 #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  logic [W-1:0] spare;
  logic [1:0]   fill;
  logic [1:0]   next_fill;
  logic         push;
  logic         pop;

  // ----------------------------------------
  // handshake terms
  // ----------------------------------------
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // next occupancy
  always_comb begin
    next_fill = fill;
    if (push && !pop) begin
      next_fill = fill + 2'h1;
    end else if (pop && !push) begin
      next_fill = fill - 2'h1;
    end
  end

  // occupancy and its flags; flags kept in flops so they leave the top clean
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fill      <= 2'h0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      fill      <= next_fill;
      in_ready  <= (next_fill != 2'h2);
      out_valid <= (next_fill != 2'h0);
    end
  end

  // head word and spare; head always leaves from a flop
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      out_data <= '0;
      spare    <= '0;
    end else begin
      if (pop) begin
        out_data <= (fill == 2'h2) ? spare : in_data;
      end else if (push && fill == 2'h0) begin
        out_data <= in_data;
      end
      if (push && ((fill == 2'h1 && !pop) || (fill == 2'h2 && pop))) begin
        spare <= in_data;
      end
    end
  end

endmodule

`default_nettype wire

/* File: tb/sdc_bank_fsm_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port checks for the bank interpreter
// ----------------------------------------
module sdc_bank_fsm_assertions #(
  parameter int NB = 2
) (
  // clock and reset
  input wire logic                    ref_clk,
  input wire logic                    rstn,
  // command pins
  input wire logic                    chip_unselected,
  input wire logic                    ras_n,
  input wire logic                    cas_n,
  input wire logic                    we_n,
  input wire logic                    cke,
  input wire logic                    bank_sel,
  input wire logic                    a10,
  // status
  input var sdc_pkg::sdc_bank_state_t bank_state [NB],
  input wire logic                    power_down,
  input wire logic                    illegal,
  input wire logic                    dq_drive
);
  // pin decode, only meaningful while clocked in
  wire logic run = cke && !power_down;
  wire logic nop = run && (chip_unselected || (ras_n && cas_n && we_n));
  wire logic quiet = run && (chip_unselected || (ras_n && cas_n));
  wire logic sel = run && !chip_unselected;
  wire logic halt = sel && ras_n && cas_n && !we_n;
  wire logic open0 = sel && !ras_n && cas_n && we_n && !bank_sel;
  wire logic shut_all = sel && !ras_n && cas_n && !we_n && a10;
  wire logic idl0 = bank_state[0] == sdc_pkg::SDC_ST_IDLE;
  wire logic act0 = bank_state[0] == sdc_pkg::SDC_ST_ACTIVE;
  wire logic rd0 = bank_state[0] == sdc_pkg::SDC_ST_READ;
  wire logic wr0 = bank_state[0] == sdc_pkg::SDC_ST_WRITE;
  wire logic rec0 = bank_state[0] == sdc_pkg::SDC_ST_RECOV;
  wire logic pre0 = bank_state[0] == sdc_pkg::SDC_ST_PRECH;
  wire logic rd1 = bank_state[1] == sdc_pkg::SDC_ST_READ;
  wire logic off1 = bank_state[1] == sdc_pkg::SDC_ST_PRECH || bank_state[1] == sdc_pkg::SDC_ST_IDLE;
  wire logic done0 = act0 || pre0;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  AST_PD_ENTER: assert property ((!cke) [*3] |=> power_down) else $error("power-down missed");
  AST_PD_EXIT: assert property (cke [*4] |=> !power_down) else $error("power-down stuck");
  AST_PD_FROZEN: assert property (power_down && $past(power_down, 3) |-> $stable(bank_state[0]) && !illegal)
    else $error("activity during power-down");
  AST_IDLE_KEEPS: assert property (quiet [*3] ##0 idl0 |=> idl0) else $error("idle bank moved");
  AST_READ_RUNS: assert property (nop [*2] ##1 ($rose(rd0) && nop) ##1 nop [*2] |-> rd0 ##1 rd0 ##1 done0)
    else $error("read burst length wrong");
  AST_HALT_CUTS: assert property (nop ##1 nop ##1 (rd0 && halt) |-> ##[1:3] done0)
    else $error("halt did not end burst");
  AST_DQ_TAIL: assert property ($fell(rd0) && act0 && !rd1 |-> ##1 dq_drive ##[1:2] !dq_drive)
    else $error("read data tail wrong");
  AST_CLOSE_ALL: assert property (nop ##1 nop ##1 (rd0 && shut_all) |-> ##[1:4] (pre0 && off1))
    else $error("close during read missed");
  AST_WRITE_RECOV: assert property (nop [*4] ##0 $fell(wr0) |-> rec0 ##1 rec0 ##1 done0)
    else $error("write recovery wrong");
  AST_REOPEN_FLAG: assert property (nop ##1 nop ##1 (act0 && open0) |-> ##[1:4] illegal)
    else $error("reopen not flagged");
endmodule

bind sdc_bank_fsm sdc_bank_fsm_assertions #(.NB(NB)) u_chk (
  .ref_clk, .rstn, .chip_unselected, .ras_n, .cas_n, .we_n, .cke, .bank_sel, .a10,
  .bank_state, .power_down, .illegal, .dq_drive
);
`default_nettype wire

/* File: tb/sdc_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// controller model and event consumer
// ----------------------------------------
module sdc_ctrl_model (
  // clock
  input  wire logic                ref_clk,
  // sequence side
  input  wire sdc_pkg::sdc_pins_t  cmd,
  input  wire logic                stall,
  // device side
  output var sdc_pkg::sdc_pins_t   pins,
  output logic                     evt_ready
);
  initial pins = 15'h3c00;
  initial evt_ready = 1'b0;
  // unselected cycles toggle the don't-care pins so a stale value never reads as a command
  always @(posedge ref_clk) begin
    if (cmd.chip_unselected)
      pins <= #1 {1'b1, ~pins[13:11], cmd.cke, ~pins[9:0]};
    else
      pins <= #1 cmd;
  end
  // consumer stalls at random, fully on request
  always @(posedge ref_clk) evt_ready <= #1 !stall && ($urandom_range(3) != 0);
endmodule
`default_nettype wire

/* File: tb/sdc_bank_fsm_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sdc_bank_fsm_tb;
  // ----------------------------------------
  // clock, wiring and bookkeeping
  // ----------------------------------------
  localparam logic [3:0] NOP = 4'h7, HALT = 4'h6, RD = 4'h5, WR = 4'h4, OPEN = 4'h3, SHUT = 4'h2, DESEL = 4'hf;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic stall = 1'b0;
  sdc_pkg::sdc_pins_t cmd = 15'h3c00;
  sdc_pkg::sdc_pins_t pins;
  sdc_pkg::sdc_bank_state_t bank_state [2];
  logic power_down, illegal, dq_drive, evt_room, evt_valid, evt_ready;
  sdc_pkg::sdc_evt_t evt_data;
  sdc_pkg::sdc_evt_t exp_q [$];
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #2 ref_clk = ~ref_clk;
  sdc_ctrl_model partner (.ref_clk, .cmd, .stall, .pins, .evt_ready);
  sdc_bank_fsm uut (
    .ref_clk, .rstn, .chip_unselected(pins.chip_unselected), .ras_n(pins.ras_n), .cas_n(pins.cas_n),
    .we_n(pins.we_n), .cke(pins.cke), .bank_sel(pins.bank), .a10(pins.a10), .col(pins.col),
    .bank_state, .power_down, .illegal, .dq_drive, .evt_room, .evt_valid, .evt_ready, .evt_data
  );
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic issue(input logic [3:0] op, input logic bk, input logic a, input logic [7:0] c);
    cmd = {op, 1'b1, bk, a, c};
    @(posedge ref_clk);
    #1;
  endtask
  task automatic rest(input int n);
    cmd = {NOP, 1'b1, 10'h000};
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic ev(input logic [1:0] k, input logic bk, input logic a, input logic [7:0] c);
    exp_q.push_back({k, bk, a, c});
  endtask
  // bounded wait: 0 bank state, 1 illegal, 2 power_down
  task automatic wait_for(input int sel, input int b, input logic [5:0] v, output int n);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < 16) begin
      @(posedge ref_clk);
      #1;
      n++;
      case (sel)
        0: hit = (bank_state[b] === v);
        1: hit = (illegal === v[0]);
        default: hit = (power_down === v[0]);
      endcase
    end
    check({15'h0, hit}, 16'h0001);
  endtask
  // ----------------------------------------
  // event scoreboard and watchdog
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (rstn && evt_valid === 1'b1 && evt_ready === 1'b1) begin
      if (exp_q.size() == 0) check(16'hffff, 16'h0000);
      else check(evt_data, exp_q.pop_front());
    end
  end
  // generous ceiling, the run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    int n;
    logic [7:0] c;
    void'($urandom(32'h86ce));
    repeat (20) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    rest(4);
    issue(DESEL, 0, 0, 8'h00);
    issue(HALT, 1, 1, 8'h00);
    rest(5);
    check(bank_state[0], sdc_pkg::SDC_ST_IDLE);
    check(power_down, 1'b0);
    issue(OPEN, 0, 0, 8'h00);
    rest(0);
    wait_for(0, 0, sdc_pkg::SDC_ST_ACTIVE, n);
    // read bursts at random columns; plain reads, halt, restart, write
    for (int k = 0; k < 6; k++) begin
      c = 8'($urandom);
      ev(0, 0, 0, c);
      if (k >= 4) ev(k == 5, 0, 0, ~c);
      issue(RD, 0, 0, c);
      if (k == 3) begin
        rest(2);
        issue(HALT, 0, 0, 8'h00);
      end
      if (k >= 4) issue(k == 5 ? WR : RD, 0, 0, ~c);
      rest(0);
      wait_for(0, 0, k == 5 ? sdc_pkg::SDC_ST_WRITE : sdc_pkg::SDC_ST_READ, n);
      if (k == 5) wait_for(0, 0, sdc_pkg::SDC_ST_RECOV, n);
      wait_for(0, 0, sdc_pkg::SDC_ST_ACTIVE, n);
      if (k < 3) check(n, 4);
      if (k == 3) check(n < 3, 1'b1);
      if (k == 4) check(n > 4, 1'b1);
      if (k == 5) check(n, 2);
    end
    // consumer stalls: two events held, the third refused
    while (exp_q.size() != 0) rest(1);
    stall = 1'b1;
    ev(0, 0, 0, 8'h11);
    ev(0, 0, 0, 8'h22);
    issue(RD, 0, 0, 8'h11);
    issue(RD, 0, 0, 8'h22);
    issue(RD, 0, 0, 8'h33);
    rest(4);
    check(evt_room, 1'b0);
    stall = 1'b0;
    wait_for(0, 0, sdc_pkg::SDC_ST_ACTIVE, n);
    while (exp_q.size() != 0) rest(1);
    rest(4);
    check(evt_valid, 1'b0);
    // close of both banks in mid-read
    issue(OPEN, 1, 0, 8'h00);
    rest(0);
    wait_for(0, 1, sdc_pkg::SDC_ST_ACTIVE, n);
    ev(0, 0, 0, 8'h44);
    ev(2, 0, 1, 8'h00);
    issue(RD, 0, 0, 8'h44);
    rest(2);
    issue(SHUT, 0, 1, 8'h00);
    rest(0);
    wait_for(0, 0, sdc_pkg::SDC_ST_PRECH, n);
    check(bank_state[1], sdc_pkg::SDC_ST_PRECH);
    wait_for(0, 0, sdc_pkg::SDC_ST_IDLE, n);
    // reopening an open row is flagged and changes nothing
    issue(OPEN, 0, 0, 8'h00);
    rest(0);
    wait_for(0, 0, sdc_pkg::SDC_ST_ACTIVE, n);
    issue(OPEN, 0, 0, 8'h00);
    rest(0);
    wait_for(1, 0, 6'h01, n);
    check(bank_state[0], sdc_pkg::SDC_ST_ACTIVE);
    ev(2, 0, 0, 8'h00);
    issue(SHUT, 0, 0, 8'h00);
    rest(0);
    wait_for(0, 0, sdc_pkg::SDC_ST_IDLE, n);
    // power-down ignores a command presented while clock enable is low
    cmd = {NOP, 1'b0, 10'h000};
    wait_for(2, 0, 6'h01, n);
    cmd = {OPEN, 1'b0, 10'h000};
    repeat (4) @(posedge ref_clk);
    #1;
    cmd = {NOP, 1'b1, 10'h000};
    wait_for(2, 0, 6'h00, n);
    rest(3);
    check(bank_state[0], sdc_pkg::SDC_ST_IDLE);
    rest(10);
    check(exp_q.size(), 16'h0000);
    wrap_up();
  end
endmodule
`default_nettype wire
